// [dv/indicator_sink.sv]
// Speaker and LED stand-in that tallies what it hears and sees.
`timescale 1ns/1ns
module indicator_sink (
  input wire logic clk_i, // System clock.
  input wire logic clr_i, // Clears both tallies.
  input wire logic speaker_i, // Speaker drive.
  input wire logic led_i, // LED drive.
  output int blinks_o, // LED turn-ons seen.
  output int tones_o // Speaker edges seen.
);
  logic spk_q; // Speaker one cycle ago.
  logic led_q; // LED one cycle ago.
  // A blink counts when the LED lights; every speaker edge counts.
  always_ff @(posedge clk_i)
  begin
    spk_q <= speaker_i;
    led_q <= led_i;
    blinks_o <= clr_i ? 0 : blinks_o + int'(led_i && !led_q);
    tones_o <= clr_i ? 0 : tones_o + int'(speaker_i != spk_q);
  end
endmodule : indicator_sink

// [dv/post_beep_blink_indicator_properties.sv]
// Port-level checks for the beep and blink indicator.
`timescale 1ns/1ns
module indicator_props
  import beep_blink_pkg::*;
#(
  parameter int unsigned CLK_HZ = 40000, // System clock rate.
  parameter int unsigned QUARTER_CYC = 100 // Cycles per 0.25 s.
) (
  input wire logic clk_i, // System clock.
  input wire logic sys_rst_i, // Asynchronous reset, active high.
  input wire beep_blink_pkg::request_t req_i, // Condition requests.
  input wire logic speaker_o, // Speaker drive.
  input wire logic led_o, // Power LED.
  input wire logic shutdown_o, // Shutdown request.
  input wire logic busy_o // Pattern playing.
);
  // The 932 Hz tone has the longest half period of all tones.
  localparam int unsigned HALF_MAX = CLK_HZ / 1864;
  int unsigned led_run_q; // Cycles since the LED last moved.
  int unsigned spk_run_q; // Cycles since the speaker last moved.
  logic led_prev_q; // LED one cycle ago.
  logic spk_prev_q; // Speaker one cycle ago.
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  // Run lengths restart on each change; the LED run starts long, so
  // the first turn-on after reset is never mistaken for a short phase.
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      led_run_q <= QUARTER_CYC;
      spk_run_q <= 0;
      led_prev_q <= 1'b0;
      spk_prev_q <= 1'b0;
    end
    else
    begin
      led_prev_q <= led_o;
      spk_prev_q <= speaker_o;
      led_run_q <= (led_o != led_prev_q) ? 0 : led_run_q + 1;
      spk_run_q <= (speaker_o != spk_prev_q) ? 0 : spk_run_q + 1;
    end
  end
  reset_quiet_a: assert property ($fell(sys_rst_i) |->
    !speaker_o && !led_o && !shutdown_o && !busy_o)
    else $error("outputs not quiet after reset");
  answer_delay_a: assert property ($rose(busy_o) |-> $past(req_i.therm |
    req_i.memory | req_i.video | req_i.update | req_i.prompt, 2))
    else $error("pattern started without a request");
  shutdown_held_a: assert property (shutdown_o |=> shutdown_o)
    else $error("shutdown request dropped");
  shutdown_idle_a: assert property (shutdown_o && $past(shutdown_o) |->
    !busy_o && !speaker_o && !led_o)
    else $error("activity after shutdown");
  idle_quiet_a: assert property (!busy_o && !$past(busy_o) |->
    !speaker_o && !led_o)
    else $error("outputs active while idle");
  tone_half_a: assert property (speaker_o && spk_prev_q |->
    spk_run_q <= HALF_MAX - 2)
    else $error("speaker high phase too long");
  led_quarter_a: assert property (busy_o && led_o != led_prev_q |->
    led_run_q >= QUARTER_CYC - 1)
    else $error("LED phase shorter than a quarter second");
  shutdown_cause_a: assert property ($rose(shutdown_o) |->
    $past(req_i.therm, 3))
    else $error("shutdown without thermal request");
endmodule : indicator_props
bind post_beep_blink_indicator indicator_props #(.CLK_HZ(CLK_HZ),
  .QUARTER_CYC(QUARTER_CYC)) props (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .req_i(req_i), .speaker_o(speaker_o), .led_o(led_o),
  .shutdown_o(shutdown_o), .busy_o(busy_o));

// [dv/post_beep_blink_indicator_tb.sv]
// Self-checking bench for the beep and blink indicator.
`timescale 1ns/1ns
`include "beep_blink_consts.svh"
module post_beep_blink_indicator_tb;
  import beep_blink_pkg::*;
  // A short quarter second keeps the run brief; tones scale with CLK_HZ.
  localparam int unsigned QC = 100;
  localparam int unsigned CLK = 40000; // Scaled clock rate for the tones.
  typedef struct {request_t req; logic led; logic tone;} row_t;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  request_t req_i = '0;
  logic speaker_o, led_o, shutdown_o, busy_o;
  logic clr = 1'b1;
  int blinks, tones, miscompares = 0, n_tests = 0, cycles = 0;
  int gap; // Measured cycles between two speaker edges.
  row_t rows[5];
  always #5 clk_i = ~clk_i;
  post_beep_blink_indicator #(.CLK_HZ(CLK), .QUARTER_CYC(QC)) uut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req_i),
    .speaker_o(speaker_o), .led_o(led_o), .shutdown_o(shutdown_o),
    .busy_o(busy_o));
  indicator_sink sink (.clk_i(clk_i), .clr_i(clr), .speaker_i(speaker_o),
    .led_i(led_o), .blinks_o(blinks), .tones_o(tones));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("%0d comparisons, %0d mismatches", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude
  task automatic at(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : at
  // Six cycles of reset, quiet outputs checked, then the request.
  task automatic restart(input request_t r);
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    req_i <= '0;
    clr <= 1'b1;
    at(5);
    check(16'({busy_o, led_o, shutdown_o, speaker_o}), 16'h0000);
    @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    req_i <= r;
    clr <= 1'b0;
  endtask : restart
  // Cycles between two speaker edges, looked at just after each clock
  // edge so the register has settled; a silent speaker ends in timeout.
  task automatic edge_gap(output int n);
    logic s;
    s = speaker_o;
    n = 0;
    while (speaker_o === s)
      at(1);
    s = speaker_o;
    while (speaker_o === s)
    begin
      at(1);
      n++;
    end
  endtask : edge_gap
  // Cut a hang short; the whole run needs about 15000 cycles.
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      conclude();
    end
  end
  initial
  begin
    rows[0] = '{6'h3D, 1'b1, 1'b1};
    rows[1] = '{6'h1D, 1'b1, 1'b1};
    rows[2] = '{6'h0D, 1'b1, 1'b1};
    rows[3] = '{6'h05, 1'b0, 1'b0};
    rows[4] = '{6'h01, 1'b0, 1'b1};
    foreach (rows[i])
    begin
      restart(rows[i].req);
      at(50);
      check(16'({busy_o, led_o}), 16'({1'b1, rows[i].led}));
      check(16'(tones != 0), 16'(rows[i].tone));
      $display("priority row %0d done", i);
    end
    restart(6'h20);
    // First tone is the high one, the second the low one.
    at(50);
    edge_gap(gap);
    check(16'(gap), 16'(CLK / (2 * `TONE_THERM_HI_HZ)));
    at(440);
    edge_gap(gap);
    check(16'(gap), 16'(CLK / (2 * `TONE_THERM_LO_HZ)));
    at(2670);
    check(16'(shutdown_o), 16'h0000);
    at(20);
    check(16'({shutdown_o, busy_o}), 16'h0002);
    check(16'(blinks), 16'h0010);
    $display("thermal test done");
    restart(6'h10);
    at(3410);
    clr = 1'b1;
    at(1);
    clr = 1'b0;
    at(40);
    check(16'(led_o), 16'h0001);
    check(16'(tones != 0), 16'h0001);
    $display("memory test done");
    // Video request stands for an absent option code.
    restart(6'h08);
    at(5190);
    clr = 1'b1;
    at(1);
    clr = 1'b0;
    at(2600);
    check(16'(tones), 16'h0000);
    check(16'(blinks), 16'h0002);
    $display("video test done");
    restart(6'h04);
    at(25);
    check(16'(led_o), 16'h0000);
    at(225);
    check(16'(led_o), 16'h0001);
    @(posedge clk_i);
    req_i <= 6'h06;
    // The pattern closes at the next quarter boundary, not at once.
    at(110);
    check(16'({busy_o, led_o}), 16'h0000);
    $display("update test done");
    conclude();
  end
endmodule : post_beep_blink_indicator_tb

// [rtl/beep_blink_consts.svh]
// Timing constants for the beep and blink indicator.
`ifndef BEEP_BLINK_CONSTS_SVH
`define BEEP_BLINK_CONSTS_SVH
`define CLK_HZ 100000000
`define TONE_LOW_HZ 932
`define TONE_THERM_HI_HZ 2000
`define TONE_THERM_LO_HZ 1500
`define QUARTER_MS 250
`define QUARTER_CYC ((`CLK_HZ / 1000) * `QUARTER_MS)
`define PROMPT_QTRS 2
`define MARK_QTRS 4
`define PAUSE_QTRS 10
`define UPDATE_QTRS 2
`define VIDEO_BEEPS 2
`define MEMORY_BEEPS 3
`define VIDEO_GROUPS 2
`define THERM_TONES 8
`endif

// [rtl/beep_blink_pkg.sv]
// Types shared by the beep and blink indicator.
package beep_blink_pkg;
  // One-hot pattern selector, also the state of the sequencer.
  typedef enum logic [5:0] {
    PAT_IDLE = 6'h01,
    PAT_PROMPT = 6'h02,
    PAT_UPDATE = 6'h04,
    PAT_VIDEO = 6'h08,
    PAT_MEMORY = 6'h10,
    PAT_THERM = 6'h20
  } pattern_t;

  // Condition requests from firmware or test logic.
  typedef struct packed {
    logic therm;
    logic memory;
    logic video;
    logic update;
    logic update_done;
    logic prompt;
  } request_t;
endpackage : beep_blink_pkg

// [rtl/post_beep_blink_indicator.sv]
// Speaker tone and power LED blink pattern generator.
// Summary of operation
// - Prompt gives one half-second 932 Hz beep.
// - Video beeps two on-off, pause, twice.
// - Memory beeps three on-off, pause, forever.
// - Thermal alternates 2000 Hz and 1500 Hz.
// - Eight thermal tones, then request shutdown.
// - Update: LED off, then half-second toggling.
// - Video LED two blinks, pause, repeating.
// - Memory LED three blinks, pause, repeating.
// - Two quarter-second blinks per thermal tone.
`timescale 1ns/1ns
`include "beep_blink_consts.svh"
module post_beep_blink_indicator #(
  parameter int unsigned CLK_HZ = `CLK_HZ, // System clock rate.
  parameter int unsigned QUARTER_CYC = `QUARTER_CYC // Cycles per 0.25 s.
) (
  input wire logic clk_i, // System clock.
  input wire logic sys_rst_i, // Asynchronous reset, active high.
  input wire beep_blink_pkg::request_t req_i, // Asynchronous requests.
  output logic speaker_o, // Tone-modulated speaker drive.
  output logic led_o, // Power LED, high is on.
  output logic shutdown_o, // Shutdown request, held once set.
  output logic busy_o // A pattern is playing.
);
  import beep_blink_pkg::*;

  // Half-period counts for each tone; the divider toggles at each.
  function automatic logic [31:0] half_period(input int unsigned hz);
    half_period = 32'(CLK_HZ / (2 * hz));
  endfunction : half_period

  localparam logic [31:0] HP_BEEP = half_period(`TONE_LOW_HZ);
  localparam logic [31:0] HP_HI = half_period(`TONE_THERM_HI_HZ);
  localparam logic [31:0] HP_LO = half_period(`TONE_THERM_LO_HZ);
  localparam logic [31:0] QTR_LAST = 32'(QUARTER_CYC - 1);

  request_t sync1_q; // First synchroniser stage, read only by second.
  request_t sync2_q; // Second synchroniser stage.
  pattern_t pat_q; // Pattern being played.
  pattern_t pat_d; // Next pattern.
  logic [31:0] qtr_cnt_q; // Cycles inside the current quarter second.
  logic qtr_tick; // Last cycle of a quarter second.
  logic [3:0] qtr_q; // Quarters elapsed in the current phase.
  logic [3:0] phase_q; // Phase within a group: beep index or tone.
  logic [1:0] group_q; // Completed groups, used by video only.
  logic tone_en; // Speaker tone gated on.
  logic [31:0] tone_hp; // Selected half period.
  logic [31:0] tone_cnt_q; // Tone divider counter.
  logic tone_q; // Square wave.
  logic led_q; // LED drive register.
  logic upd_on_q; // Update LED phase, starts off.
  logic shut_q; // Shutdown latch.

  // Pins come from another domain: two flops before any logic.
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= req_i;
      sync2_q <= sync1_q;
    end
  end

  assign qtr_tick = (qtr_cnt_q == QTR_LAST);

  // The tick is free running only while a pattern plays, so each
  // pattern begun from idle starts on a whole quarter; a thermal preemption keeps the count.
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      qtr_cnt_q <= '0;
    else if (pat_q == PAT_IDLE || qtr_tick)
      qtr_cnt_q <= '0;
    else
      qtr_cnt_q <= qtr_cnt_q + 32'h1;
  end

  // priority choice of one pattern
  // Only an idle sequencer accepts a request; a playing pattern is
  // never preempted except by thermal trip, the most urgent one.
  // the video request is trusted to mean no option code.
  always_comb
  begin
    pat_d = pat_q;
    if (sync2_q.therm && pat_q != PAT_THERM && !shut_q)
      pat_d = PAT_THERM;
    else if (pat_q == PAT_IDLE)
    begin
      if (sync2_q.memory)
        pat_d = PAT_MEMORY;
      else if (sync2_q.video)
        pat_d = PAT_VIDEO;
      else if (sync2_q.update && !sync2_q.update_done)
        pat_d = PAT_UPDATE;
      else if (sync2_q.prompt)
        pat_d = PAT_PROMPT;
    end
  end

  // Sequencer: quarter, phase and group counters plus pattern state.
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pat_q <= PAT_IDLE;
      qtr_q <= '0;
      phase_q <= '0;
      group_q <= '0;
    end
    else if (pat_d != pat_q)
    begin
      pat_q <= pat_d;
      qtr_q <= '0;
      phase_q <= '0;
      group_q <= '0;
    end
    else if (qtr_tick)
    begin
      qtr_q <= qtr_q + 4'h1;
      unique case (pat_q)
        PAT_IDLE: qtr_q <= '0;
        PAT_PROMPT:
          if (qtr_q == 4'(`PROMPT_QTRS - 1))
            pat_q <= PAT_IDLE;
        // toggle every half second until done
        PAT_UPDATE:
        begin
          if (qtr_q == 4'(`UPDATE_QTRS - 1))
            qtr_q <= '0;
          if (sync2_q.update_done)
            pat_q <= PAT_IDLE;
        end
        // video two beeps, pause, two groups, then quiet; memory three beeps, pause, forever
        // LED keeps repeating the group after beeps end
        PAT_VIDEO, PAT_MEMORY:
        begin
          if (phase_q < 4'(pat_q == PAT_VIDEO ? `VIDEO_BEEPS
                                              : `MEMORY_BEEPS))
          begin
            if (qtr_q == 4'(2 * `MARK_QTRS - 1))
            begin
              qtr_q <= '0;
              phase_q <= phase_q + 4'h1;
            end
          end
          // pause closes the group, which repeats
          else if (qtr_q == 4'(`PAUSE_QTRS - 1))
          begin
            qtr_q <= '0;
            phase_q <= '0;
            if (group_q != 2'(`VIDEO_GROUPS))
              group_q <= group_q + 2'h1;
          end
        end
        PAT_THERM:
          if (qtr_q == 4'(`MARK_QTRS - 1))
          begin
            qtr_q <= '0;
            phase_q <= phase_q + 4'h1;
            if (phase_q == 4'(`THERM_TONES - 1))
              pat_q <= PAT_IDLE;
          end
        default: pat_q <= PAT_IDLE;
      endcase
    end
  end

  // Speaker gating and tone half period for the current pattern position.
  always_comb
  begin
    tone_en = 1'b0;
    tone_hp = HP_BEEP;
    unique case (pat_q)
      PAT_PROMPT: tone_en = 1'b1;
      PAT_VIDEO: tone_en = (group_q < 2'(`VIDEO_GROUPS)) &&
                           (phase_q < 4'(`VIDEO_BEEPS)) &&
                           (qtr_q < 4'(`MARK_QTRS));
      PAT_MEMORY: tone_en = (phase_q < 4'(`MEMORY_BEEPS)) &&
                            (qtr_q < 4'(`MARK_QTRS));
      // even tones high, odd tones low
      PAT_THERM:
      begin
        tone_en = 1'b1;
        tone_hp = phase_q[0] ? HP_LO : HP_HI;
      end
      default: tone_en = 1'b0;
    endcase
  end

  // tone divider from the clock; restarts when gated off.
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      tone_cnt_q <= '0;
      tone_q <= 1'b0;
    end
    else if (!tone_en)
    begin
      tone_cnt_q <= '0;
      tone_q <= 1'b0;
    end
    else if (tone_cnt_q >= tone_hp - 32'h1)
    begin
      tone_cnt_q <= '0;
      tone_q <= !tone_q;
    end
    else
      tone_cnt_q <= tone_cnt_q + 32'h1;
  end

  // LED register; video and memory light it in their marks only, thermal on even quarters, update by its toggle, prompt never.
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      led_q <= 1'b0;
    else
      unique case (pat_q)
        // first half second off, then toggling each half second
        PAT_UPDATE: led_q <= upd_on_q;
        PAT_VIDEO: led_q <= (phase_q < 4'(`VIDEO_BEEPS)) &&
                            (qtr_q < 4'(`MARK_QTRS));
        PAT_MEMORY: led_q <= (phase_q < 4'(`MEMORY_BEEPS)) &&
                             (qtr_q < 4'(`MARK_QTRS));
        PAT_THERM: led_q <= !qtr_q[0];
        default: led_q <= 1'b0;
      endcase
  end

  // Update toggle: a half period flag flips each half second. It is
  // cleared outside the update pattern, so the LED always opens dark.
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      upd_on_q <= 1'b0;
    else if (pat_q != PAT_UPDATE)
      upd_on_q <= 1'b0;
    else if (qtr_tick && qtr_q == 4'(`UPDATE_QTRS - 1))
      upd_on_q <= !upd_on_q;
  end

  // shutdown latches after the eighth tone, until reset.
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      shut_q <= 1'b0;
    else if (pat_q == PAT_THERM && qtr_tick &&
             qtr_q == 4'(`MARK_QTRS - 1) &&
             phase_q == 4'(`THERM_TONES - 1))
      shut_q <= 1'b1;
  end

  assign speaker_o = tone_q;
  assign led_o = led_q;
  assign shutdown_o = shut_q;
  assign busy_o = (pat_q != PAT_IDLE);
endmodule : post_beep_blink_indicator
